/* File: rtl/isr_pkg.sv */
// Constants and carrier types for the interrupt status and read-acknowledge block
package isr_pkg;

	// ----------------------------------------
	// Register offsets in the I/O space
	// ----------------------------------------
	localparam logic [7:0]  OFS_STATUS_ACK   = 8'h4a;
	localparam logic [7:0]  OFS_ENABLE_MASK  = 8'h4c;
	localparam logic [7:0]  OFS_EVENT_FLAGS  = 8'h4e;

	// ----------------------------------------
	// Status bit positions
	// ----------------------------------------
	localparam int BIT_SUMMARY      = 0;
	localparam int BIT_HOST_FAULT   = 1;
	localparam int BIT_SEND_DONE    = 2;
	localparam int BIT_CTRL_FRAME   = 3;
	localparam int BIT_FRAME_ARRIV  = 4;
	localparam int BIT_EARLY_ARRIV  = 5;
	localparam int BIT_SW_IRQ       = 6;
	localparam int BIT_CNT_NEAR_OVF = 7;
	localparam int BIT_LINK_CHANGE  = 8;
	localparam int BIT_SEND_XFER    = 9;
	localparam int BIT_RECV_XFER    = 10;
	localparam int FLAG_LO          = 1;
	localparam int FLAG_HI          = 10;

	// ----------------------------------------
	// Masks and reset values
	// ----------------------------------------
	// Bits cleared by a read of the acknowledging view
	localparam logic [10:1] ACK_CLEAR_MASK  = 10'h3b4;
	// Bits cleared by writing a one to the event flags register
	localparam logic [10:1] W1C_MASK        = 10'h3b4;
	localparam logic [10:1] FLAGS_RESET     = 10'h000;
	localparam logic [10:1] ENABLE_RESET    = 10'h000;
	localparam logic [15:0] READ_IDLE       = 16'h0000;
	localparam logic [4:0]  RESERVED_ZERO   = 5'h00;

	// ----------------------------------------
	// Event inputs from the surrounding engines
	// ----------------------------------------
	typedef struct packed {
		logic hostAbort;          // Target or master abort seen
		logic wholeChipResetBit;  // Global reset control bit set
		logic dmaResetBit;        // DMA reset control bit set
		logic sendOkNotify;       // Frame with send_done_request_flag sent
		logic sendError;          // Any frame failed to send
		logic sendResultAdvance;  // Write to send_result_queue advanced it
		logic controlFrame;       // MAC control frame received
		logic framesHeld;         // Complete frames in receive_buffer
		logic bufferDrained;      // Receive bus master emptied the buffer
		logic headComplete;       // Head frame fully received
		logic softwareIrqTrigger; // Interrupt request control bit set
		logic countdownExpired;   // Host interval countdown expired
		logic countersNearOvf;    // A statistics counter reached half scale
		logic countersAllRead;    // Every statistics counter has been read
		logic sendXferDone;       // Send bus master finished a frame
		logic sendXferNotify;     // Its control word asked for notification
		logic recvXferDone;       // Receive bus master finished a frame
	} isr_events_t;

endpackage

/* File: rtl/isr_flag.sv */
// One sticky status flag where a set outranks a clear
`timescale 1ns/100ps
module isr_flag (
	input  wire logic core_clk,
	input  wire logic rst_n,
	input  wire logic setIn,
	input  wire logic clrIn,
	output logic      flag
);
	logic next_flag;

	always_comb begin
		next_flag = flag;
		if (clrIn) begin
			next_flag = 1'b0;
		end
		if (setIn) begin
			next_flag = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			flag <= 1'b0;
		end else begin
			flag <= next_flag;
		end
	end
endmodule // isr_flag

/* File: rtl/isr_status_ack.sv */
// Interrupt event flags, enable mask and read-acknowledge view
// How it works
// RULE1: Acknowledging view reads exactly like the ordinary event flags register.
// RULE2: Its read clears six events; other flags stay untouched.
// RULE3: Its read also clears the whole enable mask.
// RULE4: Bit 0 is the OR of enabled flags, same as the interrupt line.
// RULE5: Bus target or master abort sets the host bus fault flag.
// RULE6: Host fault ignores write-one; only reset or DMA reset bits clear it.
// RULE7: Send-done sets on notified success or on any send error.
// RULE8: Send-done clears only when the result queue is advanced.
// RULE9: Control frame received sets bit 3; write-one clears it.
// RULE10: Bit 4 is set while complete frames sit in the buffer.
// RULE11: Bit 4 is cleared by the receive bus master, no software write.
// RULE12: Software keeps bit 4 disabled and masks it when reading.
// RULE13: Bit 5 sets when head bytes exceed threshold; write-one clears it.
// RULE14: Head frame complete negates bit 5 and asserts bit 4.
// RULE15: Bit 6 sets on software trigger or countdown expiry; write-one clears.
// RULE16: Bit 7 sets when a statistics counter nears overflow.
// RULE17: Bit 7 clears once all statistics counters are read.
// RULE18: Bit 8 sets on any PHY link change; write-one clears it.
// RULE19: Bit 9 sets on notified send transfer done; write-one clears.
// RULE20: Software finds finished frames from the send list pointer.
// RULE21: Bit 10 sets on receive transfer done; write-one clears it.
// RULE22: Bits 15 to 11 read zero; software writes zero.
// RULE23: Enable bits 1 to 10 gate their flags; mask resets to zero.
// RULE24: Flags reset to zero; writing ones clears indication bits.
// RULE25: Read clearing acts on captured bits; same-cycle events survive.
`timescale 1ns/100ps
module isr_status_ack
	import isr_pkg::*;
#(
	parameter int THRESH_W = 11
) (
	input  wire logic                core_clk,
	input  wire logic                rst_n,
	input  wire logic [7:0]          regAddr,
	input  wire logic                regRd,
	input  wire logic                regWr,
	input  wire logic [15:0]         regWdata,
	output logic      [15:0]         regRdata,
	output logic                     regRdValid,
	input  wire isr_events_t         events,
	input  wire logic [THRESH_W-1:0] earlyArrivalThreshold,
	input  wire logic [THRESH_W-1:0] headByteCount,
	input  wire logic                phyLinkPin,
	output logic                     irqLine
);
	// ----------------------------------------
	// Access decode
	// ----------------------------------------
	logic        ackRead;
	logic        flagsWrite;
	logic        enableWrite;
	logic [10:1] flagVec;
	logic [10:1] setVec;
	logic [10:1] clrVec;
	logic [10:1] enable;
	logic [10:1] next_enable;
	logic        summary;
	logic [15:0] statusWord;
	logic [15:0] next_regRdata;
	logic        next_regRdValid;

	assign ackRead     = regRd && (regAddr == OFS_STATUS_ACK);
	assign flagsWrite  = regWr && (regAddr == OFS_EVENT_FLAGS);
	assign enableWrite = regWr && (regAddr == OFS_ENABLE_MASK);

	// ----------------------------------------
	// Link status pin synchroniser and change detect
	// ----------------------------------------
	logic linkMeta;
	logic linkSync;
	logic linkLast;
	logic linkChange;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			linkMeta <= 1'b0;
			linkSync <= 1'b0;
			linkLast <= 1'b0;
		end else begin
			linkMeta <= phyLinkPin;
			linkSync <= linkMeta;
			linkLast <= linkSync;
		end
	end

	assign linkChange = linkSync ^ linkLast; // RULE18

	// ----------------------------------------
	// Set and clear terms per flag
	// ----------------------------------------
	always_comb begin
		setVec = '0;
		clrVec = '0;
		setVec[BIT_HOST_FAULT]   = events.hostAbort; // RULE5
		clrVec[BIT_HOST_FAULT]   = events.wholeChipResetBit | events.dmaResetBit; // RULE6
		setVec[BIT_SEND_DONE]    = events.sendOkNotify | events.sendError; // RULE7
		clrVec[BIT_SEND_DONE]    = events.sendResultAdvance; // RULE8
		setVec[BIT_CTRL_FRAME]   = events.controlFrame; // RULE9
		setVec[BIT_FRAME_ARRIV]  = events.framesHeld | events.headComplete; // RULE10 RULE14
		clrVec[BIT_FRAME_ARRIV]  = events.bufferDrained; // RULE11
		setVec[BIT_EARLY_ARRIV]  = (headByteCount > earlyArrivalThreshold)
			&& !events.headComplete; // RULE13
		clrVec[BIT_EARLY_ARRIV]  = events.headComplete; // RULE14
		setVec[BIT_SW_IRQ]       = events.softwareIrqTrigger | events.countdownExpired; // RULE15
		setVec[BIT_CNT_NEAR_OVF] = events.countersNearOvf; // RULE16
		clrVec[BIT_CNT_NEAR_OVF] = events.countersAllRead; // RULE17
		setVec[BIT_LINK_CHANGE]  = linkChange; // RULE18
		setVec[BIT_SEND_XFER]    = events.sendXferDone & events.sendXferNotify; // RULE19
		setVec[BIT_RECV_XFER]    = events.recvXferDone; // RULE21
		// Write-one clears on the indication bits
		if (flagsWrite) begin
			clrVec = clrVec | (regWdata[10:1] & W1C_MASK); // RULE24 RULE9 RULE13
		end
		// Read side clearing only hits bits captured in the returned word
		if (ackRead) begin
			clrVec = clrVec | (flagVec & ACK_CLEAR_MASK); // RULE2 RULE25
		end
	end

	// ----------------------------------------
	// Flag storage
	// ----------------------------------------
	for (genvar i = FLAG_LO; i <= FLAG_HI; i++) begin : g_flag
		isr_flag u_flag (
			.core_clk (core_clk),
			.rst_n    (rst_n),
			.setIn    (setVec[i]),
			.clrIn    (clrVec[i]),
			.flag     (flagVec[i])
		); // RULE24 RULE25
	end

	// ----------------------------------------
	// Enable mask
	// ----------------------------------------
	always_comb begin
		next_enable = enable;
		if (enableWrite) begin
			next_enable = regWdata[10:1];
		end
		if (ackRead) begin
			next_enable = ENABLE_RESET; // RULE3
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			enable <= ENABLE_RESET; // RULE23
		end else begin
			enable <= next_enable;
		end
	end

	// ----------------------------------------
	// Summary and interrupt line
	// ----------------------------------------
	assign summary    = |(flagVec & enable); // RULE4 RULE23
	assign irqLine    = summary;
	assign statusWord = {RESERVED_ZERO, flagVec, summary}; // RULE22

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always_comb begin
		next_regRdata   = READ_IDLE;
		next_regRdValid = regRd;
		if (regRd) begin
			case (regAddr)
				OFS_STATUS_ACK:  next_regRdata = statusWord; // RULE1
				OFS_EVENT_FLAGS: next_regRdata = statusWord;
				OFS_ENABLE_MASK: next_regRdata = {RESERVED_ZERO, enable, 1'b0};
				default:         next_regRdata = READ_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			regRdata   <= READ_IDLE;
			regRdValid <= 1'b0;
		end else begin
			regRdata   <= next_regRdata;
			regRdValid <= next_regRdValid;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_ack_read;
		regRd && (regAddr == OFS_STATUS_ACK);
	endsequence

	sequence s_flags_read;
		regRd && (regAddr == OFS_EVENT_FLAGS);
	endsequence

	a_ack_same_word: assert property (s_ack_read |=> regRdValid
		&& regRdata == $past(statusWord))
		else $error("Ack read word differs from status word"); // RULE1

	a_ack_clears_six: assert property ((ackRead && ((setVec & ACK_CLEAR_MASK) == '0))
		|=> (flagVec & ACK_CLEAR_MASK) == '0)
		else $error("Ack read left an acknowledged flag set"); // RULE2

	a_ack_keeps_rest: assert property ((ackRead && (clrVec & ~ACK_CLEAR_MASK) == '0
		&& (setVec & ~ACK_CLEAR_MASK) == '0)
		|=> (flagVec & ~ACK_CLEAR_MASK) == ($past(flagVec) & ~ACK_CLEAR_MASK))
		else $error("Ack read disturbed an unacknowledged flag"); // RULE2

	a_ack_mask_gone: assert property (s_ack_read |=> (enable == '0) && !irqLine)
		else $error("Ack read did not clear enable mask"); // RULE3

	a_summary_bit: assert property (s_flags_read |=> regRdata[0] == $past(irqLine))
		else $error("Summary bit disagrees with interrupt line"); // RULE4

	a_fault_sticky: assert property ((flagVec[BIT_HOST_FAULT] && !events.wholeChipResetBit
		&& !events.dmaResetBit) |=> flagVec[BIT_HOST_FAULT])
		else $error("Host fault cleared without reset bit"); // RULE6

	a_senddone_hold: assert property ((flagVec[BIT_SEND_DONE] && !events.sendResultAdvance)
		|=> flagVec[BIT_SEND_DONE])
		else $error("Send done cleared without queue advance"); // RULE8

	a_head_done: assert property (events.headComplete
		|=> !flagVec[BIT_EARLY_ARRIV] && flagVec[BIT_FRAME_ARRIV])
		else $error("Head complete did not move early to arrived"); // RULE14

	a_event_kept: assert property ((ackRead && setVec[BIT_SEND_XFER])
		|=> flagVec[BIT_SEND_XFER])
		else $error("Event lost during acknowledging read"); // RULE25

	a_reserved_zero: assert property (regRdValid |-> regRdata[15:11] == RESERVED_ZERO)
		else $error("Reserved bits read nonzero"); // RULE22

	a_w1c_ctrl: assert property ((flagsWrite && regWdata[BIT_CTRL_FRAME]
		&& !events.controlFrame) |=> !flagVec[BIT_CTRL_FRAME])
		else $error("Write one did not clear control frame flag"); // RULE9

endmodule // isr_status_ack

/* File: testbench/isr_host_model.sv */
// Host driver model issuing one register access per clock cycle
`timescale 1ns/100ps
module isr_host_model
	import isr_pkg::*;
(
	input  wire logic        core_clk,
	output logic      [7:0]  regAddr,
	output logic             regRd,
	output logic             regWr,
	output logic      [15:0] regWdata
);
	// ----------------------------------------
	// Idle values
	// ----------------------------------------
	initial begin
		regAddr = 8'h00;
		regRd = 1'b0;
		regWr = 1'b0;
		regWdata = 16'h0000;
	end

	// ----------------------------------------
	// One cycle of the register bus
	// ----------------------------------------
	task automatic cycle(input logic rd, input logic wr, input logic [7:0] a,
		input logic [15:0] d);
		regRd = rd;
		regWr = wr;
		regAddr = a;
		// Reserved bits zero, receive-complete never enabled
		regWdata = {5'h00, d[10:5], d[4] & (a != OFS_ENABLE_MASK), d[3:0]};
		@(negedge core_clk);
	endtask
endmodule // isr_host_model

/* File: testbench/test_interrupt_status_read_ack.sv */
// Self-checking bench with a cycle model of the status flags
`timescale 1ns/100ps
module test_interrupt_status_read_ack
	import isr_pkg::*;
;
	logic        core_clk;
	logic        rst_n;
	logic [7:0]  regAddr;
	logic        regRd;
	logic        regWr;
	logic [15:0] regWdata;
	logic [15:0] regRdata;
	logic        regRdValid;
	isr_events_t ev;
	logic [10:0] thr;
	logic [10:0] hbc;
	logic        pin;
	logic        irqLine;
	logic        linkSet;
	logic [10:1] mf;
	logic [10:1] me;
	logic        mRun;
	logic        expV;
	logic [15:0] expD;
	logic [10:1] sv;
	logic [10:1] cv;
	logic [7:0]  adr [4];
	int          n_fail;
	int          check_count;
	int          r;

	isr_host_model host (.core_clk(core_clk), .regAddr(regAddr), .regRd(regRd),
		.regWr(regWr), .regWdata(regWdata));
	isr_status_ack #(.THRESH_W(11)) DUT (.core_clk(core_clk), .rst_n(rst_n),
		.regAddr(regAddr), .regRd(regRd), .regWr(regWr), .regWdata(regWdata),
		.regRdata(regRdata), .regRdValid(regRdValid), .events(ev),
		.earlyArrivalThreshold(thr), .headByteCount(hbc), .phyLinkPin(pin),
		.irqLine(irqLine));

	// ----------------------------------------
	// Reference model
	// ----------------------------------------
	assign sv = {ev.recvXferDone, ev.sendXferDone & ev.sendXferNotify, linkSet,
		ev.countersNearOvf, ev.softwareIrqTrigger | ev.countdownExpired,
		(hbc > thr) & !ev.headComplete, ev.framesHeld | ev.headComplete,
		ev.controlFrame, ev.sendOkNotify | ev.sendError, ev.hostAbort};
	assign cv = {3'h0, ev.countersAllRead, 1'b0, ev.headComplete, ev.bufferDrained, 1'b0,
		ev.sendResultAdvance, ev.wholeChipResetBit | ev.dmaResetBit}
		| ((regWr && regAddr == 8'h4e) ? regWdata[10:1] & 10'h3b4 : 10'h000)
		| ((regRd && regAddr == 8'h4a) ? 10'h3b4 : 10'h000);

	function automatic logic [15:0] rdv(input logic [7:0] a);
		case (a)
			8'h4a, 8'h4e: rdv = {5'h00, mf, |(mf & me)};
			8'h4c: rdv = {5'h00, me, 1'b0};
			default: rdv = 16'h0000;
		endcase
	endfunction

	always @(posedge core_clk) begin
		mRun <= rst_n;
		if (!rst_n) begin
			mf <= 10'h000;
			me <= 10'h000;
			expV <= 1'b0;
			expD <= 16'h0000;
		end else begin
			expV <= regRd;
			expD <= regRd ? rdv(regAddr) : 16'h0000;
			mf <= sv | (mf & ~cv);
			if (regWr && regAddr == 8'h4c)
				me <= regWdata[10:1];
			if (regRd && regAddr == 8'h4a)
				me <= 10'h000;
		end
	end

	// ----------------------------------------
	// Comparisons
	// ----------------------------------------
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	always @(negedge core_clk) begin
		if (mRun === 1'b1) begin
			chk("irqLine", {15'h0, |(mf & me)}, {15'h0, irqLine});
			chk("regRdValid", {15'h0, expV}, {15'h0, regRdValid});
			if (expV)
				chk("regRdata", expD, regRdata);
		end
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ----------------------------------------
	// Stimulus
	// ----------------------------------------
	task automatic idle(input int n);
		repeat (n) host.cycle(1'b0, 1'b0, 8'h00, 16'h0000);
	endtask

	task automatic linkFlip();
		pin = ~pin;
		idle(2);
		linkSet = 1'b1;
		idle(1);
		linkSet = 1'b0;
		idle(4);
	endtask

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	initial begin
		n_fail = 0;
		check_count = 0;
		rst_n = 1'b0;
		ev = '0;
		thr = 11'h000;
		hbc = 11'h000;
		pin = 1'b0;
		linkSet = 1'b0;
		adr = '{8'h4a, 8'h4c, 8'h4e, 8'h50};
		void'($urandom(46));
		repeat (12) @(negedge core_clk);
		rst_n = 1'b1;
		for (int i = 0; i < 4; i++) host.cycle(1'b1, 1'b0, adr[i], 16'h0000);
		linkFlip();
		linkFlip();
		host.cycle(1'b1, 1'b0, 8'h4e, 16'h0000);
		host.cycle(1'b0, 1'b1, 8'h4c, 16'h07fe);
		ev.controlFrame = 1'b1;
		host.cycle(1'b1, 1'b0, 8'h4a, 16'h0000);
		ev = '0;
		host.cycle(1'b1, 1'b0, 8'h4e, 16'h0000);
		repeat (3000) begin
			// Sparse event pulses, also result-queue advance and counter reads
			ev = 17'($urandom & $urandom & $urandom);
			thr = 11'($urandom);
			hbc = 11'($urandom);
			r = $urandom % 8;
			host.cycle(r == 0, r == 1 || r == 2, adr[$urandom % 4], 16'($urandom));
		end
		ev = '0;
		host.cycle(1'b1, 1'b0, 8'h4e, 16'h0000);
		rst_n = 1'b0;
		idle(2);
		rst_n = 1'b1;
		host.cycle(1'b1, 1'b0, 8'h4e, 16'h0000);
		host.cycle(1'b1, 1'b0, 8'h4c, 16'h0000);
		idle(2);
		tally_and_finish();
	end
endmodule // test_interrupt_status_read_ack
